// File: shared/tdra_pkg.sv
// Constants, field layout and state types for the cable reflectometry amplitude result bank.
// Assumes a 32-bit AXI4-Lite slave port and a reflectometry engine on the same clock.
// Behaviour
// RL1: Results meaningful only after diagnostic-done reads one.
// RL2: Bits 15 and 7 ignore writes, read zero.
// RL3: Two seven-bit read-only fields, reset to zero.
// RL4: Word 0x0186 bits 14:8 hold transmit peak four.
// RL5: Word 0x0186 bits 6:0 hold transmit peak three.
// RL6: Word 0x0187 bits 14:8 hold receive peak one.
// RL7: Word 0x0187 bits 6:0 hold transmit peak five.
// RL8: Word 0x0188 bits 14:8 hold receive peak three.
// RL9: Word 0x0188 bits 6:0 hold receive peak two.
// RL10: Word 0x0185 holds transmit peaks two and one.
// RL11: Load fields before done; hold until next run.
package tdra_pkg;

  // Bus geometry.
  localparam int unsigned ADDR_W   = 12;
  localparam int unsigned DATA_W   = 32;
  localparam int unsigned IDX_W    = 10;
  localparam int unsigned IDX_LSB  = 2;
  localparam int unsigned WORD_W   = 16;

  // Register indices; the byte address is four times the index.
  localparam logic [IDX_W-1:0] IDX_DIAG_CONTROL = 10'h01e;
  localparam logic [IDX_W-1:0] IDX_AMP_TX1_TX2  = 10'h185;
  localparam logic [IDX_W-1:0] IDX_AMP_TX3_TX4  = 10'h186;
  localparam logic [IDX_W-1:0] IDX_AMP_TX5_RX1  = 10'h187;
  localparam logic [IDX_W-1:0] IDX_AMP_RX2_RX3  = 10'h188;

  // Amplitude field layout inside a result word.
  localparam int unsigned AMP_W      = 7;
  localparam int unsigned AMP_HI_LSB = 8;
  localparam int unsigned AMP_LO_LSB = 0;
  localparam int unsigned RSVD_HI    = 15;
  localparam int unsigned RSVD_LO    = 7;
  localparam logic [AMP_W-1:0] AMP_RESET = 7'h00;
  localparam logic               RSVD_VALUE = 1'h0;

  // Diagnostic-done position in the control view.
  localparam int unsigned DONE_BIT = 1;

  // Field slots, one per reflection peak.
  localparam int unsigned FIELD_COUNT = 8;
  localparam int unsigned F_TX1 = 0;
  localparam int unsigned F_TX2 = 1;
  localparam int unsigned F_TX3 = 2;
  localparam int unsigned F_TX4 = 3;
  localparam int unsigned F_TX5 = 4;
  localparam int unsigned F_RX1 = 5;
  localparam int unsigned F_RX2 = 6;
  localparam int unsigned F_RX3 = 7;

  // AXI response codes.
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  // Write channel states.
  typedef enum logic [1:0] {
    WR_COLLECT = 2'h1,
    WR_RESP    = 2'h2
  } tdra_wr_state_t;

  // Read channel states.
  typedef enum logic [1:0] {
    RD_IDLE = 2'h1,
    RD_RESP = 2'h2
  } tdra_rd_state_t;

endpackage

// File: logic/tdra_amp_field.sv
// One seven-bit amplitude result field with synchronous reset and load.
// Assumes the load pulse and value come from logic on the same clock.
`timescale 1ns/100ps
module tdra_amp_field
  import tdra_pkg::*;
(
  // Clock and reset.
  input  wire logic             clk,
  input  wire logic             rst,
  // Capture request and value.
  input  wire logic             load,
  input  wire logic [AMP_W-1:0] ampIn,
  // Held amplitude.
  output logic      [AMP_W-1:0] amp
);

  logic [AMP_W-1:0] amp_d;
  logic [AMP_W-1:0] amp_q;

  // The value changes only on a load, so software sees a stable result between runs.
  always_comb
  begin
    amp_d = amp_q;
    if (load)
    begin
      amp_d = ampIn; // RL11
    end
  end

  // Field returns to zero on reset.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      amp_q <= AMP_RESET; // RL3
    end
    else
    begin
      amp_q <= amp_d;
    end
  end

  assign amp = amp_q;

endmodule // tdra_amp_field

// File: logic/tdra_results.sv
// Top of the reflectometry amplitude result bank with its AXI4-Lite slave.
// Assumes the engine on the same clock pulses runStart and runDone with amplitudes valid at done.
`timescale 1ns/100ps
module tdra_results
  import tdra_pkg::*;
(
  // Clock and reset.
  input  wire logic              clk,
  input  wire logic              rst,
  // Reflectometry engine results.
  input  wire logic              runStart,
  input  wire logic              runDone,
  input  wire logic [AMP_W-1:0]  ampTx1In,
  input  wire logic [AMP_W-1:0]  ampTx2In,
  input  wire logic [AMP_W-1:0]  ampTx3In,
  input  wire logic [AMP_W-1:0]  ampTx4In,
  input  wire logic [AMP_W-1:0]  ampTx5In,
  input  wire logic [AMP_W-1:0]  ampRx1In,
  input  wire logic [AMP_W-1:0]  ampRx2In,
  input  wire logic [AMP_W-1:0]  ampRx3In,
  // Diagnostic status.
  output logic                   diagDone,
  // AXI4-Lite write address.
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic [2:0]        s_axi_awprot,
  // AXI4-Lite write data.
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  input  wire logic [DATA_W-1:0] s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  // AXI4-Lite write response.
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  output logic      [1:0]        s_axi_bresp,
  // AXI4-Lite read address.
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic [2:0]        s_axi_arprot,
  // AXI4-Lite read data.
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  output logic      [DATA_W-1:0] s_axi_rdata,
  output logic      [1:0]        s_axi_rresp
);

  // Register index of a byte address.
  function automatic logic [IDX_W-1:0] regIndex(input logic [ADDR_W-1:0] addr);
    regIndex = addr[IDX_LSB +: IDX_W];
  endfunction

  // True when the address names a word of this bank.
  function automatic logic regHit(input logic [ADDR_W-1:0] addr);
    logic [IDX_W-1:0] idx;
    idx = regIndex(addr);
    regHit = (idx == IDX_DIAG_CONTROL) || (idx == IDX_AMP_TX1_TX2) ||
             (idx == IDX_AMP_TX3_TX4) || (idx == IDX_AMP_TX5_RX1) ||
             (idx == IDX_AMP_RX2_RX3);
  endfunction

  // Builds a result word; reserved bits are forced to zero here, never stored.
  function automatic logic [DATA_W-1:0] ampWord(input logic [AMP_W-1:0] hi,
                                                input logic [AMP_W-1:0] lo);
    logic [DATA_W-1:0] w;
    w = '0;
    w[AMP_HI_LSB +: AMP_W] = hi;
    w[AMP_LO_LSB +: AMP_W] = lo;
    w[RSVD_HI] = RSVD_VALUE; // RL2
    w[RSVD_LO] = RSVD_VALUE; // RL2
    ampWord = w;
  endfunction

  logic [AMP_W-1:0] ampIn  [FIELD_COUNT];
  logic [AMP_W-1:0] ampVal [FIELD_COUNT];

  // Engine inputs gathered into slots by peak.
  always_comb
  begin
    ampIn[F_TX1] = ampTx1In;
    ampIn[F_TX2] = ampTx2In;
    ampIn[F_TX3] = ampTx3In;
    ampIn[F_TX4] = ampTx4In;
    ampIn[F_TX5] = ampTx5In;
    ampIn[F_RX1] = ampRx1In;
    ampIn[F_RX2] = ampRx2In;
    ampIn[F_RX3] = ampRx3In;
  end

  // Every field captures on the same done pulse, so all words belong to one run.
  for (genvar g = 0; g < FIELD_COUNT; g++)
  begin : gField
    tdra_amp_field uField (
      .clk   (clk),
      .rst   (rst),
      .load  (runDone), // RL11
      .ampIn (ampIn[g]),
      .amp   (ampVal[g])
    );
  end

  logic loaded_d;
  logic loaded_q;
  logic done_d;
  logic done_q;

  // Done rises one cycle after the capture, so a reader that sees it finds fresh fields.
  // A done event in the cycle of a new start wins, so a finished run is never hidden.
  always_comb
  begin
    loaded_d = runDone;
    done_d   = done_q;
    if (runStart)
    begin
      done_d = 1'b0;
    end
    if (loaded_q)
    begin
      done_d = 1'b1; // RL11 RL1
    end
  end

  // Status flops.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      loaded_q <= 1'b0;
      done_q   <= 1'b0;
    end
    else
    begin
      loaded_q <= loaded_d;
      done_q   <= done_d;
    end
  end

  // Read data mux; unmapped words read as zero.
  logic [DATA_W-1:0] readWord;
  always_comb
  begin
    readWord = '0;
    unique case (regIndex(s_axi_araddr))
      IDX_DIAG_CONTROL: readWord[DONE_BIT] = done_q; // RL1
      IDX_AMP_TX1_TX2:  readWord = ampWord(ampVal[F_TX2], ampVal[F_TX1]); // RL10
      IDX_AMP_TX3_TX4:  readWord = ampWord(ampVal[F_TX4], ampVal[F_TX3]); // RL4 RL5
      IDX_AMP_TX5_RX1:  readWord = ampWord(ampVal[F_RX1], ampVal[F_TX5]); // RL6 RL7
      IDX_AMP_RX2_RX3:  readWord = ampWord(ampVal[F_RX3], ampVal[F_RX2]); // RL8 RL9
      default:          readWord = '0;
    endcase
  end

  tdra_wr_state_t    wrState_d;
  tdra_wr_state_t    wrState_q;
  logic              awGot_d;
  logic              awGot_q;
  logic              wGot_d;
  logic              wGot_q;
  logic [ADDR_W-1:0] awAddr_d;
  logic [ADDR_W-1:0] awAddr_q;
  logic              awready_d;
  logic              awready_q;
  logic              wready_d;
  logic              wready_q;
  logic              bvalid_d;
  logic              bvalid_q;
  logic [1:0]        bresp_d;
  logic [1:0]        bresp_q;
  logic [ADDR_W-1:0] wrAddr;

  // Write path: address and data are taken in either order; every word is read-only,
  // so a write only earns a response and never changes a field.
  always_comb
  begin
    wrState_d = wrState_q;
    awGot_d   = awGot_q;
    wGot_d    = wGot_q;
    awAddr_d  = awAddr_q;
    awready_d = awready_q;
    wready_d  = wready_q;
    bvalid_d  = bvalid_q;
    bresp_d   = bresp_q;
    wrAddr    = awAddr_q;
    unique case (wrState_q)
      WR_COLLECT:
      begin
        if (s_axi_awvalid && awready_q)
        begin
          awGot_d   = 1'b1;
          awAddr_d  = s_axi_awaddr;
          wrAddr    = s_axi_awaddr;
          awready_d = 1'b0;
        end
        if (s_axi_wvalid && wready_q)
        begin
          wGot_d   = 1'b1;
          wready_d = 1'b0;
        end
        if (awGot_d && wGot_d)
        begin
          wrState_d = WR_RESP;
          bvalid_d  = 1'b1;
          bresp_d   = regHit(wrAddr) ? RESP_OKAY : RESP_DECERR; // RL2 RL3
        end
      end
      WR_RESP:
      begin
        if (s_axi_bready)
        begin
          wrState_d = WR_COLLECT;
          bvalid_d  = 1'b0;
          awGot_d   = 1'b0;
          wGot_d    = 1'b0;
          awready_d = 1'b1;
          wready_d  = 1'b1;
        end
      end
      default:
      begin
        wrState_d = WR_COLLECT;
        awready_d = 1'b1;
        wready_d  = 1'b1;
      end
    endcase
  end

  // Write path flops.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      wrState_q <= WR_COLLECT;
      awGot_q   <= 1'b0;
      wGot_q    <= 1'b0;
      awAddr_q  <= '0;
      awready_q <= 1'b1;
      wready_q  <= 1'b1;
      bvalid_q  <= 1'b0;
      bresp_q   <= RESP_OKAY;
    end
    else
    begin
      wrState_q <= wrState_d;
      awGot_q   <= awGot_d;
      wGot_q    <= wGot_d;
      awAddr_q  <= awAddr_d;
      awready_q <= awready_d;
      wready_q  <= wready_d;
      bvalid_q  <= bvalid_d;
      bresp_q   <= bresp_d;
    end
  end

  tdra_rd_state_t    rdState_d;
  tdra_rd_state_t    rdState_q;
  logic              arready_d;
  logic              arready_q;
  logic              rvalid_d;
  logic              rvalid_q;
  logic [DATA_W-1:0] rdata_d;
  logic [DATA_W-1:0] rdata_q;
  logic [1:0]        rresp_d;
  logic [1:0]        rresp_q;

  // Read path: data is sampled when the address is taken and held until rready.
  always_comb
  begin
    rdState_d = rdState_q;
    arready_d = arready_q;
    rvalid_d  = rvalid_q;
    rdata_d   = rdata_q;
    rresp_d   = rresp_q;
    unique case (rdState_q)
      RD_IDLE:
      begin
        if (s_axi_arvalid && arready_q)
        begin
          rdState_d = RD_RESP;
          arready_d = 1'b0;
          rvalid_d  = 1'b1;
          rdata_d   = readWord;
          rresp_d   = regHit(s_axi_araddr) ? RESP_OKAY : RESP_DECERR;
        end
      end
      RD_RESP:
      begin
        if (s_axi_rready)
        begin
          rdState_d = RD_IDLE;
          arready_d = 1'b1;
          rvalid_d  = 1'b0;
        end
      end
      default:
      begin
        rdState_d = RD_IDLE;
        arready_d = 1'b1;
        rvalid_d  = 1'b0;
      end
    endcase
  end

  // Read path flops.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      rdState_q <= RD_IDLE;
      arready_q <= 1'b1;
      rvalid_q  <= 1'b0;
      rdata_q   <= '0;
      rresp_q   <= RESP_OKAY;
    end
    else
    begin
      rdState_q <= rdState_d;
      arready_q <= arready_d;
      rvalid_q  <= rvalid_d;
      rdata_q   <= rdata_d;
      rresp_q   <= rresp_d;
    end
  end

  // All outputs come straight from flops.
  assign diagDone      = done_q;
  assign s_axi_awready = awready_q;
  assign s_axi_wready  = wready_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;

endmodule // tdra_results

// File: tb/tdra_results_assertions.sv
// Checker for the amplitude result bank, watching its top ports only.
// Assumes it is bound to tdra_results and shares its single clock.
`timescale 1ns/100ps
module tdra_results_chk
  import tdra_pkg::*;
(
  // Clock and reset.
  input wire logic        clk,
  input wire logic        rst,
  // Engine and status.
  input wire logic        runStart,
  input wire logic        runDone,
  input wire logic        diagDone,
  // Bus handshakes.
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  // Read answer.
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // A read is taken, then answered while the address channel is shut.
  sequence s_rdTake; s_axi_arvalid && s_axi_arready; endsequence
  sequence s_rdAns; s_axi_rvalid && !s_axi_arready; endsequence
  property p_rdLat; s_rdTake |=> s_rdAns; endproperty
  a_rdLat: assert property (p_rdLat) else $error("read answer late");
  property p_rdHold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
  a_rdHold: assert property (p_rdHold) else $error("read data moved");
  property p_rsvd; s_axi_rvalid |-> s_axi_rdata[31:15] == 17'h0 && !s_axi_rdata[7]; endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bit set");
  property p_decErr; s_axi_rvalid && s_axi_rresp == RESP_DECERR |-> s_axi_rdata == 32'h0; endproperty
  a_decErr: assert property (p_decErr) else $error("unmapped data");
  property p_wrLat; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> s_axi_bvalid; endproperty
  a_wrLat: assert property (p_wrLat) else $error("write answer late");
  // Done follows the load by two cycles and never appears on its own.
  property p_doneLat; runDone |-> ##2 diagDone; endproperty
  a_doneLat: assert property (p_doneLat) else $error("done late");
  property p_doneCause; $rose(diagDone) |-> $past(runDone, 2); endproperty
  a_doneCause: assert property (p_doneCause) else $error("done uncaused");
  property p_doneClr; runStart && !$past(runDone) |=> !diagDone; endproperty
  a_doneClr: assert property (p_doneClr) else $error("done not cleared");
  property p_doneHold; diagDone && !runStart |=> diagDone; endproperty
  a_doneHold: assert property (p_doneHold) else $error("done dropped");
endmodule // tdra_results_chk

bind tdra_results tdra_results_chk u_tdra_results_chk (.clk(clk), .rst(rst),
  .runStart(runStart), .runDone(runDone), .diagDone(diagDone),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp));

// File: tb/tdra_results_tb.sv
// Self-checking bench for the amplitude result bank over AXI4-Lite.
// Assumes the bank answers each bus request under a bounded wait.
`timescale 1ns/100ps
module tdra_results_tb
  import tdra_pkg::*;
;
  logic clk = 1'b0, rst = 1'b1, runStart = 1'b0, runDone = 1'b0, diagDone;
  logic [AMP_W-1:0] ampIn [FIELD_COUNT] = '{default: 7'h00};
  logic [AMP_W-1:0] mAmp [FIELD_COUNT];
  logic mDone;
  logic awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0;
  logic awRdy, wRdy, bVld, arRdy, rVld;
  logic [ADDR_W-1:0] awa = 12'h000, ara = 12'h000;
  logic [31:0] wd = 32'h0, rData;
  logic [1:0] bResp, rResp;
  logic [33:0] rq [$];
  logic [1:0] bq [$];
  logic [IDX_W-1:0] ixs [7] = '{IDX_DIAG_CONTROL, IDX_AMP_TX1_TX2, IDX_AMP_TX3_TX4,
    IDX_AMP_TX5_RX1, IDX_AMP_RX2_RX3, 10'h184, 10'h3ff};
  int err_total = 0, tests_run = 0, cyc = 0;

  tdra_results u_tdra_results (.clk(clk), .rst(rst), .runStart(runStart), .runDone(runDone),
    .ampTx1In(ampIn[F_TX1]), .ampTx2In(ampIn[F_TX2]), .ampTx3In(ampIn[F_TX3]),
    .ampTx4In(ampIn[F_TX4]), .ampTx5In(ampIn[F_TX5]), .ampRx1In(ampIn[F_RX1]),
    .ampRx2In(ampIn[F_RX2]), .ampRx3In(ampIn[F_RX3]), .diagDone(diagDone),
    .s_axi_awvalid(awv), .s_axi_awready(awRdy), .s_axi_awaddr(awa), .s_axi_awprot(3'h0),
    .s_axi_wvalid(wv), .s_axi_wready(wRdy), .s_axi_wdata(wd), .s_axi_wstrb(4'hf),
    .s_axi_bvalid(bVld), .s_axi_bready(bry), .s_axi_bresp(bResp),
    .s_axi_arvalid(arv), .s_axi_arready(arRdy), .s_axi_araddr(ara), .s_axi_arprot(3'h0),
    .s_axi_rvalid(rVld), .s_axi_rready(rry), .s_axi_rdata(rData), .s_axi_rresp(rResp));

  // Free-running clock.
  initial forever #2 clk = ~clk;

  // Expected {resp, data} for a register index, from the bench's model.
  function automatic logic [33:0] expw(input logic [IDX_W-1:0] i);
    case (i)
      IDX_DIAG_CONTROL: expw = {RESP_OKAY, 30'h0, mDone, 1'b0};
      IDX_AMP_TX1_TX2: expw = {RESP_OKAY, 17'h0, mAmp[F_TX2], 1'b0, mAmp[F_TX1]};
      IDX_AMP_TX3_TX4: expw = {RESP_OKAY, 17'h0, mAmp[F_TX4], 1'b0, mAmp[F_TX3]};
      IDX_AMP_TX5_RX1: expw = {RESP_OKAY, 17'h0, mAmp[F_RX1], 1'b0, mAmp[F_TX5]};
      IDX_AMP_RX2_RX3: expw = {RESP_OKAY, 17'h0, mAmp[F_RX3], 1'b0, mAmp[F_RX2]};
      default: expw = {RESP_DECERR, 32'h0};
    endcase
  endfunction

  task chk(input logic [33:0] g, input logic [33:0] e);
    begin
      tests_run++;
      if (g !== e)
      begin
        err_total++;
        $display("MISMATCH %0t got %h expected %h", $time, g, e);
      end
    end
  endtask

  task final_report();
    begin
      if (err_total == 0 && tests_run > 0)
        $display("SIMULATION PASSED");
      else
        $display("SIMULATION FAILED");
      $finish;
    end
  endtask

  // Read one word; rready rises with the address or, at random, a cycle after the take,
  // so the answer must also stand while rready is low.
  task rd(input logic [IDX_W-1:0] i);
    bit slow;
    begin
      @(posedge clk);
      slow = 1'($urandom);
      rq.push_back(expw(i));
      arv <= 1'b1;
      ara <= {i, 2'b00};
      rry <= !slow;
      do @(posedge clk); while (arRdy !== 1'b1);
      arv <= 1'b0;
      if (slow)
      begin
        @(posedge clk);
        rry <= 1'b1;
      end
      do @(posedge clk); while (rVld !== 1'b1);
      rry <= 1'b0;
    end
  endtask

  // Write one word; each channel drops its valid only once taken.
  task wr(input logic [IDX_W-1:0] i, input logic [31:0] d);
    bit ka, kw;
    logic [33:0] e;
    begin
      @(posedge clk);
      e = expw(i);
      bq.push_back(e[33:32]);
      awv <= 1'b1;
      wv <= 1'b1;
      awa <= {i, 2'b00};
      wd <= d;
      bry <= 1'b1;
      ka = 1'b0;
      kw = 1'b0;
      do
      begin
        @(posedge clk);
        if (awRdy === 1'b1 && !ka)
        begin
          ka = 1'b1;
          awv <= 1'b0;
        end
        if (wRdy === 1'b1 && !kw)
        begin
          kw = 1'b1;
          wv <= 1'b0;
        end
      end
      while (!(ka && kw));
      do @(posedge clk); while (bVld !== 1'b1);
      bry <= 1'b0;
    end
  endtask

  task rdAll();
    for (int k = 0; k < 7; k++) rd(ixs[k]);
  endtask

  // One engine run; inputs change after the load so holding is exercised.
  task run(input bit ones);
    int k;
    begin
      @(posedge clk);
      runStart <= 1'b1;
      mDone = 1'b0;
      @(posedge clk);
      runStart <= 1'b0;
      runDone <= 1'b1;
      for (k = 0; k < FIELD_COUNT; k++)
      begin
        mAmp[k] = ones ? 7'h7f : AMP_W'($urandom);
        ampIn[k] <= mAmp[k];
      end
      @(posedge clk);
      runDone <= 1'b0;
      for (k = 0; k < FIELD_COUNT; k++) ampIn[k] <= AMP_W'($urandom);
      @(posedge clk);
      chk({33'h0, diagDone}, 34'h0);
      @(posedge clk);
      chk({33'h0, diagDone}, 34'h1);
      mDone = 1'b1;
    end
  endtask

  // Answers are compared against the oldest note of their kind.
  always @(posedge clk)
  begin
    if (rVld === 1'b1 && rry === 1'b1) chk({rResp, rData}, rq.pop_front());
    if (bVld === 1'b1 && bry === 1'b1) chk({32'h0, bResp}, {32'h0, bq.pop_front()});
  end

  // Hang guard; the whole run needs well under a thousand cycles.
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      err_total++;
      final_report();
    end
  end

  // Main sequence.
  initial
  begin
    void'($urandom(32'he0e0e813));
    mAmp = '{default: 7'h00};
    mDone = 1'b0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    rdAll();
    run(1'b0);
    rdAll();
    run(1'b1);
    rdAll();
    for (int k = 0; k < 7; k++) wr(ixs[k], 32'hffffffff);
    rdAll();
    @(posedge clk);
    runStart <= 1'b1;
    @(posedge clk);
    runStart <= 1'b0;
    mDone = 1'b0;
    rdAll();
    run(1'b0);
    rdAll();
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    mAmp = '{default: 7'h00};
    mDone = 1'b0;
    rdAll();
    final_report();
  end
endmodule // tdra_results_tb
